// File: src/sac_pkg.sv
// Constants, register map and state types of the converter control block.
//
// Behaviour
// - Input at or above upper reference yields FFh, no overflow flag.
// - Input at or below lower reference yields 00h.
// - Sample phase, then hold phase with eight decisions, MSB first.
// - While on, sample and conversion phases repeat with no software help.
// - Setting power-on enables converter and starts converting the channel.
// - Each finished conversion sets the done flag; no interrupt exists.
// - Result stays unchanged until the next conversion finishes.
// - Control write with power-on set aborts, clears done, restarts.
// - Result read or control write clears the done flag.
// - Power-on bit switches converter and amplifier on and off together.
// - Channel codes 0 to 4 pick inputs zero to four; higher unassigned.
// - Result register is read-only, eight bits, 00h to FFh.
// - Clock /2 by default, undivided with speed, /4 whenever slow.
// - Gain-stage select routes input through the amplifier, else bypass.
// - Amplifier register bits 7:4 and 1:0 read zero, writes ignored.
// - Runs normally in wait, off in halt, stabilises after wakeup.
package sac_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] CSR_INDEX = 8'h34;
    localparam logic [7:0] RES_INDEX = 8'h35;
    localparam logic [7:0] AMP_INDEX = 8'h36;
    localparam logic [7:0] CSR_ADDR  = {CSR_INDEX[5:0], 2'h0};
    localparam logic [7:0] RES_ADDR  = {RES_INDEX[5:0], 2'h0};
    localparam logic [7:0] AMP_ADDR  = {AMP_INDEX[5:0], 2'h0};

    ////////////////////////////////////////////////////////////////////////
    // Field positions and reset values.
    localparam int EOC_BIT   = 7;
    localparam int SPEED_BIT = 6;
    localparam int PWR_BIT   = 5;
    localparam int CH_MSB    = 2;
    localparam int SLOW_BIT  = 3;
    localparam int GAIN_BIT  = 2;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RES_RESET = 8'h00;
    localparam logic [7:0] AMP_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing counts in converter clock ticks and CPU clock cycles.
    localparam logic [3:0]  SAMPLE_TICKS  = 4'h3;
    localparam logic [7:0]  SAR_FIRST     = 8'h80;
    localparam int unsigned STAB_CYC_DEF  = 100;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer states.
    typedef enum logic [1:0] {
        SAC_OFF    = 2'b00,
        SAC_STAB   = 2'b01,
        SAC_SAMPLE = 2'b10,
        SAC_CONV   = 2'b11
    } sac_state_e;

endpackage

// File: src/sac_clk_div.sv
// Converter clock enable divider.
`timescale 1ns/100ps
module sac_clk_div
(
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Control.
    input  wire logic clear,
    input  wire logic slow,
    input  wire logic speed,
    // Converter tick.
    output logic      tick
);

    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } sac_div_s;

    sac_div_s s;
    sac_div_s next_s;
    logic [1:0] limit;

    // Pick the divide ratio and count towards it.
    always_comb
    begin
        next_s = s;
        limit  = slow ? 2'h3 : (speed ? 2'h0 : 2'h1);
        if (clear)
        begin
            next_s.cnt  = 2'h0;
            next_s.tick = 1'b0;
        end
        else if (s.cnt >= limit)
        begin
            next_s.cnt  = 2'h0;
            next_s.tick = 1'b1;
        end
        else
        begin
            next_s.cnt  = s.cnt + 2'h1;
            next_s.tick = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign tick = s.tick;

endmodule

// File: src/sac_sar.sv
// Successive approximation register, one decision per step.
`timescale 1ns/100ps
module sac_sar
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset.
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Sequencing.
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             step,
    input  wire logic             comp,
    // Trial code and completion.
    output logic [WIDTH-1:0]      code,
    output logic                  done
);

    typedef struct packed {
        logic [WIDTH-1:0] code;
        logic [WIDTH-1:0] mask;
        logic             busy;
        logic             done;
    } sac_sar_s;

    sac_sar_s s;
    sac_sar_s next_s;

    // A decision keeps the trial bit when the input is not below it.
    always_comb
    begin
        next_s      = s;
        next_s.done = 1'b0;
        if (abort)
            next_s.busy = 1'b0;
        else if (start)
        begin
            next_s.code = {1'b1, {(WIDTH-1){1'b0}}};
            next_s.mask = {1'b1, {(WIDTH-1){1'b0}}};
            next_s.busy = 1'b1;
        end
        else if (step && s.busy)
        begin
            // All ones keeps every bit, all zeros drops every bit.
            next_s.code = (comp ? s.code : (s.code & ~s.mask))
                          | (s.mask >> 1);
            next_s.mask = s.mask >> 1;
            if (s.mask[0])
            begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= '0;
        else
            s <= next_s;
    end

    assign code = s.code;
    assign done = s.done;

endmodule

// File: src/sac_top.sv
// Converter control block with AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
module sac_top
#(
    parameter int unsigned STAB_CYCLES = sac_pkg::STAB_CYC_DEF
)
(
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // System power mode.
    input  wire logic        halt_mode,
    // Analog front end.
    input  wire logic        comparator,
    output logic [7:0]       dac_code,
    output logic [2:0]       channel_select,
    output logic             sample_enable,
    output logic             converter_on,
    output logic             amplifier_on,
    output logic             gain_stage_select
);

    typedef struct packed {
        sac_pkg::sac_state_e st;
        logic [7:0]          haddr_q;
        logic                wr_q;
        logic                eoc;
        logic                speed;
        logic                converter_power_on;
        logic [2:0]          chan;
        logic                slow;
        logic                gain;
        logic [7:0]          result;
        logic [2:0]          chan_out;
        logic                conv_on;
        logic                sample_en;
        logic [3:0]          scnt;
        logic [15:0]         stab;
        logic [31:0]         rdata;
        logic                ready;
        logic                start;
        logic                restart;
    } sac_top_s;

    localparam sac_top_s RST = '{
        st:      sac_pkg::SAC_OFF,
        ready:   1'b1,
        default: '0
    };

    sac_top_s   s;
    sac_top_s   next_s;
    logic       tick;
    logic       sar_done;
    logic [7:0] sar_code;
    logic       take;
    logic       rd_res;
    logic       wr_csr;
    logic       wr_amp;
    logic       enter_sample;

    ////////////////////////////////////////////////////////////////////////
    // Converter clock enable.
    sac_clk_div u_div
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .clear   (s.restart),
        .slow    (s.slow),
        .speed   (s.speed),
        .tick    (tick)
    );

    // Bit decision engine.
    sac_sar #(.WIDTH(8)) u_sar
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (s.start),
        .abort   (s.st != sac_pkg::SAC_CONV),
        .step    (tick && (s.st == sac_pkg::SAC_CONV)),
        .comp    (comparator),
        .code    (sar_code),
        .done    (sar_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode: address phase taken on hready, writes act in data phase.
    always_comb
    begin
        take   = hsel && htrans[1] && hready;
        rd_res = take && !hwrite && (haddr[7:0] == sac_pkg::RES_ADDR);
        wr_csr = s.wr_q && (s.haddr_q == sac_pkg::CSR_ADDR);
        wr_amp = s.wr_q && (s.haddr_q == sac_pkg::AMP_ADDR);
    end

    // Registers, sequencer and read data.
    always_comb
    begin
        next_s         = s;
        next_s.start   = 1'b0;
        next_s.restart = 1'b0;
        next_s.ready   = 1'b1;
        next_s.wr_q    = take && hwrite;
        enter_sample   = 1'b0;
        if (take)
            next_s.haddr_q = haddr[7:0];

        // Control writes; bits four and three are dropped.
        if (wr_csr)
        begin
            next_s.speed              = hwdata[sac_pkg::SPEED_BIT];
            next_s.converter_power_on = hwdata[sac_pkg::PWR_BIT];
            next_s.chan               = hwdata[sac_pkg::CH_MSB:0];
        end
        // Only slow and gain bits are stored.
        if (wr_amp)
        begin
            next_s.slow = hwdata[sac_pkg::SLOW_BIT];
            next_s.gain = hwdata[sac_pkg::GAIN_BIT];
        end

        // Done flag clears on result read or control write.
        if (wr_csr || rd_res)
            next_s.eoc = 1'b0;

        // Sequencer, halt first, then power, then restart on write.
        if (halt_mode)
        begin
            next_s.st   = sac_pkg::SAC_STAB;
            next_s.stab = 16'(STAB_CYCLES);
        end
        else if (!next_s.converter_power_on)
            next_s.st = sac_pkg::SAC_OFF;
        else if (wr_csr && s.st != sac_pkg::SAC_STAB)
            enter_sample = 1'b1;
        else
        begin
            case (s.st)
                sac_pkg::SAC_OFF:
                    enter_sample = 1'b1;
                sac_pkg::SAC_STAB:
                begin
                    if (s.stab == 16'h0000)
                        enter_sample = 1'b1;
                    else
                        next_s.stab = s.stab - 16'h0001;
                end
                sac_pkg::SAC_SAMPLE:
                begin
                    if (tick)
                    begin
                        if (s.scnt == sac_pkg::SAMPLE_TICKS - 4'h1)
                        begin
                            next_s.st    = sac_pkg::SAC_CONV;
                            next_s.start = 1'b1;
                        end
                        else
                            next_s.scnt = s.scnt + 4'h1;
                    end
                end
                sac_pkg::SAC_CONV:
                begin
                    if (sar_done)
                    begin
                        next_s.result = sar_code;
                        next_s.eoc    = 1'b1;
                        enter_sample  = 1'b1;
                    end
                end
                default:
                    next_s.st = sac_pkg::SAC_OFF;
            endcase
        end

        // Entering a sample phase latches the channel and aligns the tick.
        if (enter_sample)
        begin
            next_s.st       = sac_pkg::SAC_SAMPLE;
            next_s.scnt     = 4'h0;
            next_s.restart  = 1'b1;
            next_s.chan_out = next_s.chan;
        end

        // Converter and amplifier powered together.
        next_s.conv_on   = next_s.converter_power_on && !halt_mode;
        next_s.sample_en = (next_s.st == sac_pkg::SAC_SAMPLE);

        // Read data from the values being stored this cycle.
        next_s.rdata = 32'h0000_0000;
        if (take && !hwrite)
        begin
            case (haddr[7:0])
                sac_pkg::CSR_ADDR:
                    next_s.rdata = {24'h000000, next_s.eoc, next_s.speed,
                                    next_s.converter_power_on, 2'h0,
                                    next_s.chan};
                sac_pkg::RES_ADDR:
                    next_s.rdata = {24'h000000, next_s.result};
                sac_pkg::AMP_ADDR:
                    next_s.rdata = {24'h000000, 4'h0, next_s.slow,
                                    next_s.gain, 2'h0};
                default:
                    next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // State register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= RST;
        else
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state registers; hresp is tied low.
    assign hreadyout         = s.ready;
    assign hresp             = 1'b0;
    assign hrdata            = s.rdata;
    assign dac_code          = sar_code;
    assign channel_select    = s.chan_out;
    assign sample_enable     = s.sample_en;
    assign converter_on      = s.conv_on;
    assign amplifier_on      = s.conv_on;
    assign gain_stage_select = s.gain;

endmodule

// File: bench/sac_asserts.sv
// Port-level checks of the converter control block, bound to its top.
`timescale 1ns/100ps
module sac_asserts
#(
    parameter int unsigned STAB_CYCLES = 4
)
(
    // Clock and reset.
    input wire logic        hclk,
    input wire logic        hresetn,
    // Register bus.
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // Power mode and analog side.
    input wire logic        halt_mode,
    input wire logic [7:0]  dac_code,
    input wire logic [2:0]  channel_select,
    input wire logic        sample_enable,
    input wire logic        converter_on,
    input wire logic        amplifier_on,
    input wire logic        gain_stage_select
);
    ////////////////////////////////////////////////////////////////////////
    // Address phases of writes to the control and amplifier registers.
    logic wr_csr;
    logic wr_amp;
    assign wr_csr = hsel && htrans[1] && hready && hwrite
                    && haddr[7:0] == sac_pkg::CSR_ADDR;
    assign wr_amp = hsel && htrans[1] && hready && hwrite
                    && haddr[7:0] == sac_pkg::AMP_ADDR;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////
    // Checks on outputs against their causes.
    rdata_width_a: assert property (hrdata[31:8] == 24'h0)
        else $error("Read data above the low byte is not zero.");
    amp_follows_a: assert property (amplifier_on == converter_on)
        else $error("Amplifier power differs from converter power.");
    halt_stops_a: assert property (halt_mode |=> !converter_on)
        else $error("Converter stays on in halt mode.");
    sample_powered_a: assert property (sample_enable |-> converter_on)
        else $error("Sampling while the converter is off.");
    chan_at_sample_a: assert property (
        $changed(channel_select) |-> sample_enable)
        else $error("Channel changed outside a sampling phase.");
    first_trial_a: assert property (
        $fell(sample_enable) && converter_on && !halt_mode
        |-> ##[0:8] dac_code == 8'h80)
        else $error("Conversion did not start from the top bit.");
    gain_write_a: assert property (
        wr_amp ##1 1 |=> gain_stage_select == $past(hwdata[2]))
        else $error("Gain select does not follow the written bit.");
    power_start_a: assert property (
        wr_csr ##1 (hwdata[5] && !halt_mode) |=> ##[0:2] sample_enable)
        else $error("Control write with power on did not start sampling.");
    power_off_a: assert property (
        wr_csr ##1 !hwdata[5] |=> ##[0:1] !converter_on && !sample_enable)
        else $error("Clearing power did not stop the converter.");

    // Main scenarios reached.
    cover property (wr_csr ##1 hwdata[5]);
    cover property ($fell(sample_enable) && converter_on);
    cover property ($fell(halt_mode));
endmodule

bind sac_top sac_asserts #(.STAB_CYCLES(STAB_CYCLES)) u_chk
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .halt_mode(halt_mode), .dac_code(dac_code),
    .channel_select(channel_select), .sample_enable(sample_enable),
    .converter_on(converter_on), .amplifier_on(amplifier_on),
    .gain_stage_select(gain_stage_select)
);

// File: bench/sac_front.sv
// Behavioural analog front end: input mux, gain stage, hold and comparator.
`timescale 1ns/100ps
module sac_front
(
    // Clock.
    input  wire logic            hclk,
    // Levels of the five inputs, set by the bench.
    input  wire logic [4:0][7:0] level,
    // Control from the block.
    input  wire logic [7:0]      dac_code,
    input  wire logic [2:0]      channel_select,
    input  wire logic            sample_enable,
    input  wire logic            converter_on,
    input  wire logic            gain_stage_select,
    // Decision to the block.
    output logic                 comparator
);
    logic [7:0] held = 8'h00;
    logic [7:0] pin;
    logic       junk = 1'b0;

    // Gain of eight, clipped at full scale.
    assign pin = !gain_stage_select ? level[channel_select]
               : (level[channel_select] > 8'h1f) ? 8'hff
               : {level[channel_select][4:0], 3'h0};

    // The capacitor tracks only while connected; unpowered output churns.
    always_ff @(posedge hclk)
    begin
        junk <= ~junk;
        if (sample_enable && channel_select < 3'h5)
            held <= pin;
    end

    // High when the held level is at or above the trial code.
    assign comparator = converter_on ? (held >= dac_code) : junk;
endmodule

// File: bench/tb_sar_adc_control.sv
// Self-checking bench of the converter control block over its register bus.
`timescale 1ns/100ps
module tb_sar_adc_control;
    logic            hclk = 1'b0;
    logic            hresetn = 1'b0;
    logic            hsel = 1'b0;
    logic [31:0]     haddr = 32'h0;
    logic [1:0]      htrans = 2'h0;
    logic            hwrite = 1'b0;
    logic [31:0]     hwdata = 32'h0;
    logic            halt_mode = 1'b0;
    logic [4:0][7:0] level = {8'h0c, 8'ha5, 8'h5a, 8'h00, 8'hff};
    logic            hreadyout, hresp, comparator, sample_enable;
    logic            converter_on, amplifier_on, gain_stage_select;
    logic [31:0]     hrdata;
    logic [7:0]      dac_code, r;
    logic [2:0]      channel_select;
    int              miscompares = 0;
    int              num_checks = 0;
    int              n1, n2, n4;

    sac_top #(.STAB_CYCLES(4)) uut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .halt_mode(halt_mode), .comparator(comparator),
        .dac_code(dac_code), .channel_select(channel_select),
        .sample_enable(sample_enable), .converter_on(converter_on),
        .amplifier_on(amplifier_on), .gain_stage_select(gain_stage_select)
    );

    sac_front u_front
    (
        .hclk(hclk), .level(level), .dac_code(dac_code),
        .channel_select(channel_select), .sample_enable(sample_enable),
        .converter_on(converter_on), .gain_stage_select(gain_stage_select),
        .comparator(comparator)
    );

    // Free-running 25 MHz clock.
    initial
    begin
        forever #20 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compares a seen byte with the expected one.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // Waits for hready high at a rising edge, within a bound.
    task automatic edge_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 16);
        if (hreadyout !== 1'b1)
        begin
            miscompares++;
            complete_run();
        end
    endtask

    // One single-word transfer: address phase, then data phase.
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [7:0] wd, output logic [7:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, addr};
        edge_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        edge_ready();
        rd = hrdata[7:0];
    endtask

    // Polls the control register until the done flag shows, bounded.
    task automatic wait_done(output int reads);
        logic [7:0] v;
        v = 8'h00;
        reads = 0;
        while (v[7] !== 1'b1 && reads < 200)
        begin
            xfer(1'b0, sac_pkg::CSR_ADDR, 8'h00, v);
            reads++;
        end
        if (v[7] !== 1'b1)
        begin
            miscompares++;
            complete_run();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, sac_pkg::CSR_ADDR, 8'h00, r);
        check(r, 8'h00);
        xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
        check(r, 8'h00);
        xfer(1'b1, 8'h00, 8'hff, r);
        xfer(1'b0, 8'h00, 8'h00, r);
        check(r, 8'h00);
        xfer(1'b1, sac_pkg::AMP_ADDR, 8'hff, r);
        xfer(1'b0, sac_pkg::AMP_ADDR, 8'h00, r);
        check(r, 8'h0c);
        check({7'h0, gain_stage_select}, 8'h01);
        xfer(1'b1, sac_pkg::AMP_ADDR, 8'h00, r);
        // Channel codes 0 to 4, full scale and zero among the levels.
        for (int c = 0; c < 5; c++)
        begin
            xfer(1'b1, sac_pkg::CSR_ADDR, 8'h60 | 8'(c), r);
            // Power outputs show the written bit from the same edge it lands on.
            @(posedge hclk);
            check({7'h0, converter_on & amplifier_on}, 8'h01);
            wait_done(n1);
            xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
            check(r, level[c]);
            xfer(1'b0, sac_pkg::CSR_ADDR, 8'h00, r);
            check(r, 8'h60 | 8'(c));
        end
        // Gain stage on input four at the slowest converter clock.
        // The first result after the change is discarded.
        xfer(1'b1, sac_pkg::AMP_ADDR, 8'h0c, r);
        wait_done(n1);
        xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
        wait_done(n1);
        xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
        check(r, 8'h60);
        xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
        check(r, 8'h60);
        xfer(1'b1, sac_pkg::AMP_ADDR, 8'h00, r);
        // Converter clock rates; each control write aborts and clears done.
        xfer(1'b1, sac_pkg::CSR_ADDR, 8'h62, r);
        wait_done(n1);
        xfer(1'b1, sac_pkg::CSR_ADDR, 8'h22, r);
        xfer(1'b0, sac_pkg::CSR_ADDR, 8'h00, r);
        check(r, 8'h22);
        wait_done(n2);
        xfer(1'b1, sac_pkg::AMP_ADDR, 8'h08, r);
        xfer(1'b1, sac_pkg::CSR_ADDR, 8'h62, r);
        wait_done(n4);
        check({7'h0, n1 < n2 && n2 < n4}, 8'h01);
        xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
        check(r, 8'h5a);
        xfer(1'b1, sac_pkg::AMP_ADDR, 8'h00, r);
        // Halt stops the converter; it resumes after stabilising.
        halt_mode <= 1'b1;
        repeat (3) @(posedge hclk);
        check({7'h0, converter_on}, 8'h00);
        // Clear the done flag so that only a conversion after wakeup sets it.
        xfer(1'b0, sac_pkg::RES_ADDR, 8'h00, r);
        halt_mode <= 1'b0;
        wait_done(n1);
        check({7'h0, converter_on}, 8'h01);
        // Power off stops conversions and the amplifier.
        xfer(1'b1, sac_pkg::CSR_ADDR, 8'h02, r);
        @(posedge hclk);
        check({7'h0, converter_on | amplifier_on}, 8'h00);
        repeat (60) @(posedge hclk);
        xfer(1'b0, sac_pkg::CSR_ADDR, 8'h00, r);
        check(r, 8'h02);
        // The bus response stays OKAY throughout.
        check({7'h0, hresp}, 8'h00);
        complete_run();
    end
endmodule
